//--- hw/tmz_timer_defs.vh
// Constants for the 8-bit timer with shared prescaler.
`ifndef TMZ_TIMER_DEFS_VH
`define TMZ_TIMER_DEFS_VH

// Register byte addresses on the APB slave.
`define TMZ_ADDR_OPTION 12'h000
`define TMZ_ADDR_COUNT 12'h004
`define TMZ_ADDR_INTCTL 12'h008
`define TMZ_ADDR_IRQ_STATUS 12'h00c
`define TMZ_ADDR_IRQ_CLEAR 12'h010
`define TMZ_ADDR_IRQ_ENABLE 12'h014

// Reset values.
`define TMZ_OPTION_RESET 8'hff
`define TMZ_INTCTL_RESET 8'h00
`define TMZ_COUNT_RESET 8'h00

// Option register fields.
`define TMZ_OPT_PULLUP_DIS 7
`define TMZ_OPT_EXT_IRQ_EDGE 6
`define TMZ_OPT_SRC_SEL 5
`define TMZ_OPT_EDGE_SEL 4
`define TMZ_OPT_PSC_ASSIGN 3
`define TMZ_OPT_RATE_HI 2
`define TMZ_OPT_RATE_LO 0

// Interrupt control register fields.
`define TMZ_INT_OVF_IE 5
`define TMZ_INT_OVF_FLAG 2

// Interrupt status, clear and enable layout.
`define TMZ_IRQ_OVF 0

// Timing: phase clocks per instruction cycle, inhibited cycles after a write.
`define TMZ_PHASES 4
`define TMZ_INHIBIT_INSTR 2
`define TMZ_PHASE_Q2 2'h1
`define TMZ_PHASE_Q4 2'h3

`endif

//--- hw/tmz_timer.v
// 8-bit timer/counter with a prescaler shared with the watchdog, on an APB slave.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - In timer mode without prescaler the count advances by one every instruction cycle.
// - After a write to the count, incrementing is suppressed for the next two instruction cycles.
// - Source select 0 counts instruction cycles, 1 counts transitions of the external count input.
// - In counter mode the count input's falling edge counts when edge select is 1, rising edge when 0.
// - The one prescaler serves either the timer (assign bit 0) or the watchdog (assign bit 1).
// - The rate field gives timer ratios 1:2 to 1:256 and watchdog ratios 1:1 to 1:128.
// - The timer counts undivided only while the prescaler belongs to the watchdog.
// - The prescaler count is hidden from software and a count write clears it when owned by the timer.
// - When owned by the watchdog, the clear-watchdog instruction clears the prescaler.
// - A wrap of the count from ff to 00 sets the overflow flag regardless of the enable.
// - The overflow request is raised only while both overflow flag and overflow enable are set.
// - The counter stops during sleep, so an overflow cannot wake the processor.
// - In counter mode the prescaler output is sampled into the count on the second and fourth phases.
// - The pull-up disable bit turns all port pull-ups off when 1.
// - The external interrupt edge select bit picks the rising edge when 1, falling when 0.
`include "tmz_timer_defs.vh"

module tmz_timer (
    input wire i_ref_clk,              // System clock, 10 MHz.
    input wire i_rst_n,                // Asynchronous reset, active low.
    input wire i_clk_en,               // Freezes all state while low.
    input wire i_psel,                 // APB select.
    input wire i_penable,              // APB enable.
    input wire i_pwrite,               // APB direction, high for write.
    input wire [11:0] i_paddr,         // APB byte address.
    input wire [31:0] i_pwdata,        // APB write data.
    output reg [31:0] o_prdata,        // APB read data.
    output reg o_pready,               // APB ready.
    output reg o_pslverr,              // APB error on unmapped address.
    input wire i_ext_count,            // External count pin, asynchronous.
    input wire i_sleep,                // Processor sleep level.
    input wire i_clear_watchdog,       // Clear-watchdog instruction pulse.
    input wire i_wdt_tick,             // Watchdog base oscillator tick pulse.
    output reg o_wdt_tick,             // Tick into the watchdog counter.
    output reg o_overflow_req,         // Timer overflow interrupt request.
    output reg o_port_pullup_disable,  // All port pull-ups off when high.
    output reg o_ext_irq_edge_select,  // External interrupt on rising edge when high.
    output reg o_irq                   // Level interrupt from the status block.
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam [4:0] INHIBIT_CLKS = `TMZ_INHIBIT_INSTR * `TMZ_PHASES;

    reg [7:0] option_reg;
    reg [7:0] count_reg;
    reg [7:0] intctl_reg;
    reg [7:0] irq_status_reg;
    reg [7:0] irq_enable_reg;
    reg [7:0] psc_reg;
    reg [1:0] phase_reg;
    reg [4:0] inhibit_reg;
    reg pending_reg;
    reg sync1_reg;
    reg sync2_reg;
    reg sync_prev_reg;

    wire src_ext;
    wire edge_fall;
    wire psc_to_wdt;
    wire [2:0] rate;
    wire [7:0] psc_last;
    wire ext_edge;
    wire tmr_src;
    wire psc_src;
    wire psc_done;
    wire tmr_tick;
    wire sample_phase;
    wire setup;
    wire access;
    wire wr_count;
    wire wr_intctl;
    wire wr_option;
    wire wr_clear;
    wire wr_enable;
    wire incr;
    wire overflow;
    wire [7:0] intctl_next;
    wire [7:0] irq_status_next;

    ////////////////////////////////////////////////////////////////////////////
    // Terminal count of the prescaler for the current owner and rate.

    // Returns ratio minus one: 2 << rate for the timer, 1 << rate for the watchdog.
    function [7:0] psc_terminal;
        input [2:0] r;
        input to_wdt;
        reg [8:0] ratio;
        begin
            ratio = to_wdt ? (9'h001 << r) : (9'h002 << r);
            psc_terminal = ratio[7:0] - 8'h01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Option decoding and event sources.

    assign src_ext = option_reg[`TMZ_OPT_SRC_SEL];
    assign edge_fall = option_reg[`TMZ_OPT_EDGE_SEL];
    assign psc_to_wdt = option_reg[`TMZ_OPT_PSC_ASSIGN];
    assign rate = option_reg[`TMZ_OPT_RATE_HI:`TMZ_OPT_RATE_LO];
    assign psc_last = psc_terminal(rate, psc_to_wdt);

    // Edge detection reads only the second synchroniser stage and its copy.
    assign ext_edge = edge_fall ? (sync_prev_reg & ~sync2_reg)
                                : (~sync_prev_reg & sync2_reg);

    // Timer mode takes one event per instruction cycle at the fourth phase.
    assign tmr_src = src_ext ? ext_edge : (phase_reg == `TMZ_PHASE_Q4);

    // The prescaler input follows its owner; the other party goes undivided.
    assign psc_src = psc_to_wdt ? i_wdt_tick : tmr_src;
    assign psc_done = psc_src && (psc_reg == psc_last);

    // Without the prescaler the timer takes its source one for one.
    assign tmr_tick = psc_to_wdt ? tmr_src : psc_done;

    assign sample_phase = (phase_reg == `TMZ_PHASE_Q2) || (phase_reg == `TMZ_PHASE_Q4);

    ////////////////////////////////////////////////////////////////////////////
    // APB decoding: writes take effect in the access cycle with ready high.

    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable && o_pready;
    assign wr_option = access && i_pwrite && (i_paddr == `TMZ_ADDR_OPTION);
    assign wr_count = access && i_pwrite && (i_paddr == `TMZ_ADDR_COUNT);
    assign wr_intctl = access && i_pwrite && (i_paddr == `TMZ_ADDR_INTCTL);
    assign wr_clear = access && i_pwrite && (i_paddr == `TMZ_ADDR_IRQ_CLEAR);
    assign wr_enable = access && i_pwrite && (i_paddr == `TMZ_ADDR_IRQ_ENABLE);

    // Counting stops while asleep and while a recent count write is inhibiting.
    assign incr = pending_reg && sample_phase && !i_sleep && (inhibit_reg == 5'h00) && !wr_count;
    assign overflow = incr && (count_reg == 8'hff);

    // The hardware set wins over a software clear landing in the same cycle.
    assign intctl_next = wr_intctl ? i_pwdata[7:0] : intctl_reg;
    assign irq_status_next = wr_clear ? (irq_status_reg & ~i_pwdata[7:0]) : irq_status_reg;

    ////////////////////////////////////////////////////////////////////////////
    // External input synchroniser and edge history.

    // Two flops keep a metastable pin level away from the edge detector.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync_prev_reg <= 1'b0;
        end else if (i_clk_en) begin
            sync1_reg <= i_ext_count;
            sync2_reg <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase counter: four system clocks make one instruction cycle.

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_reg <= 2'h0;
        end else if (i_clk_en) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: free-running divider, invisible to software.

    // It is cleared by a count write or a watchdog clear, whichever owner applies.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            psc_reg <= 8'h00;
        end else if (i_clk_en) begin
            if (wr_count && !psc_to_wdt) begin
                psc_reg <= 8'h00;
            end else if (i_clear_watchdog && psc_to_wdt) begin
                psc_reg <= 8'h00;
            end else if (psc_done) begin
                psc_reg <= 8'h00;
            end else if (psc_src && !(i_sleep && !psc_to_wdt)) begin
                psc_reg <= psc_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog tick output.

    // The watchdog gets the divided tick only while it owns the prescaler.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wdt_tick <= 1'b0;
        end else if (i_clk_en) begin
            o_wdt_tick <= psc_to_wdt ? psc_done : i_wdt_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending tick, sampled into the count on the second and fourth phases.

    // Holding the prescaler output until a sample phase aligns external
    // edges to the instruction clock; edges closer than two phases merge.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_count) begin
                pending_reg <= 1'b0;
            end else if (tmr_tick && !(i_sleep && !psc_to_wdt)) begin
                pending_reg <= 1'b1;
            end else if (sample_phase) begin
                pending_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count register and write inhibit.

    // A write loads the count and blocks increments for two instruction cycles.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= `TMZ_COUNT_RESET;
            inhibit_reg <= 5'h00;
        end else if (i_clk_en) begin
            if (wr_count) begin
                count_reg <= i_pwdata[7:0];
                inhibit_reg <= INHIBIT_CLKS;
            end else begin
                if (inhibit_reg != 5'h00) begin
                    inhibit_reg <= inhibit_reg - 5'h01;
                end
                if (incr) begin
                    count_reg <= count_reg + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Option, interrupt control and interrupt status registers.

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            option_reg <= `TMZ_OPTION_RESET;
            intctl_reg <= `TMZ_INTCTL_RESET;
            irq_status_reg <= 8'h00;
            irq_enable_reg <= 8'h00;
        end else if (i_clk_en) begin
            if (wr_option) begin
                option_reg <= i_pwdata[7:0];
            end
            if (wr_enable) begin
                irq_enable_reg <= i_pwdata[7:0];
            end
            // Software writes the whole register, flag included; overflow sets the flag afterwards.
            intctl_reg <= intctl_next;
            if (overflow) begin
                intctl_reg[`TMZ_INT_OVF_FLAG] <= 1'b1;
            end
            irq_status_reg <= irq_status_next;
            if (overflow) begin
                irq_status_reg[`TMZ_IRQ_OVF] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered side outputs.

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_overflow_req <= 1'b0;
            o_port_pullup_disable <= 1'b1;
            o_ext_irq_edge_select <= 1'b1;
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            o_overflow_req <= intctl_reg[`TMZ_INT_OVF_IE] & intctl_reg[`TMZ_INT_OVF_FLAG];
            o_port_pullup_disable <= option_reg[`TMZ_OPT_PULLUP_DIS];
            o_ext_irq_edge_select <= option_reg[`TMZ_OPT_EXT_IRQ_EDGE];
            o_irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: data and ready are registered in the setup cycle.

    // Ready rises for exactly one access cycle, so there are no wait states;
    // the read value is the one held at the setup edge.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            o_pready <= setup;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            if (setup) begin
                case (i_paddr)
                    `TMZ_ADDR_OPTION: begin
                        o_prdata <= {24'h000000, option_reg};
                    end
                    `TMZ_ADDR_COUNT: begin
                        o_prdata <= {24'h000000, count_reg};
                    end
                    `TMZ_ADDR_INTCTL: begin
                        o_prdata <= {24'h000000, intctl_reg};
                    end
                    `TMZ_ADDR_IRQ_STATUS: begin
                        o_prdata <= {24'h000000, irq_status_reg};
                    end
                    `TMZ_ADDR_IRQ_ENABLE: begin
                        o_prdata <= {24'h000000, irq_enable_reg};
                    end
                    `TMZ_ADDR_IRQ_CLEAR: begin
                        o_prdata <= 32'h0000_0000;
                    end
                    default: begin
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // tmz_timer
`default_nettype wire

//--- testbench/tmz_ext_source.sv
// Model of the external event source on the count pin.
`timescale 1ns/10ps
`default_nettype none
module tmz_ext_source (
    input wire logic i_ref_clk, // Bench clock.
    output logic o_pin // Count pin level.
);
    // The pin idles low until the bench asks for an edge.
    initial o_pin = 1'b0;
    // Each level is held long enough for both sample phases to see it.
    task automatic move(input logic lvl, input int hold);
        @(posedge i_ref_clk);
        o_pin <= lvl;
        repeat (hold) @(posedge i_ref_clk);
    endtask
endmodule // tmz_ext_source
`default_nettype wire

//--- testbench/tmz_timer_props.sv
// Port assertions for the shared-prescaler timer.
`timescale 1ns/10ps
`default_nettype none
module tmz_timer_props (
    input wire logic i_ref_clk, // Clock.
    input wire logic i_rst_n, // Reset, active low.
    input wire logic i_psel, // Select.
    input wire logic i_penable, // Enable.
    input wire logic i_pwrite, // Direction.
    input wire logic [11:0] i_paddr, // Address.
    input wire logic [31:0] i_pwdata, // Write data.
    input wire logic [31:0] o_prdata, // Read data.
    input wire logic o_pready, // Ready.
    input wire logic o_pslverr, // Error.
    input wire logic i_wdt_tick, // Base tick.
    input wire logic o_wdt_tick, // Tick out.
    input wire logic o_port_pullup_disable, // Pull-ups off.
    input wire logic o_ext_irq_edge_select // Edge select.
);
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [7:0] opt_seen;
    ////////////////////////////////
    // Last option value written; the pin copies must follow it.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            opt_seen <= 8'hff;
        end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h000) begin
            opt_seen <= i_pwdata[7:0];
        end
    end
    ////////////////////////////////
    // A setup cycle, and a completed write to the option register.
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    sequence opt_wr_s;
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h000;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> o_pready) else $error("ready missing after setup");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready) else $error("ready held");
    rdata_idle_zero_a: assert property (!o_pready |-> o_prdata == 32'h0) else $error("read data outside access");
    error_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    unmapped_error_a: assert property (
        setup_s ##0 (i_paddr > 12'h014 || i_paddr[1:0] != 2'b00) |=> o_pslverr) else $error("unmapped accepted");
    mapped_ok_a: assert property (
        setup_s ##0 (i_paddr <= 12'h014 && i_paddr[1:0] == 2'b00) |=> !o_pslverr) else $error("mapped refused");
    option_pins_a: assert property (
        opt_wr_s |=> ##[0:1] (o_port_pullup_disable == opt_seen[7] && o_ext_irq_edge_select == opt_seen[6]))
        else $error("option pins wrong");
    wdt_cause_a: assert property (
        o_wdt_tick |-> $past(i_wdt_tick) || $past(i_wdt_tick, 2) || $past(i_wdt_tick, 3))
        else $error("watchdog tick without cause");
endmodule // tmz_timer_props
bind tmz_timer tmz_timer_props chk_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_wdt_tick(i_wdt_tick), .o_wdt_tick(o_wdt_tick),
    .o_port_pullup_disable(o_port_pullup_disable), .o_ext_irq_edge_select(o_ext_irq_edge_select));
`default_nettype wire

//--- testbench/eight_bit_timer_with_shared_prescaler_test.sv
// Self-checking bench for the shared-prescaler timer.
`timescale 1ns/10ps
`default_nettype none
module eight_bit_timer_with_shared_prescaler_test;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pena = 1'b0, pwr = 1'b0;
    logic sleep = 1'b0, cwd = 1'b0, wtk = 1'b0, er;
    logic cke = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdat = 32'h0, rd, seed = 32'hab5b4965;
    logic [7:0] wopt[4] = '{8'h08, 8'h09, 8'h0a, 8'h00};
    wire [31:0] rdat;
    wire rdy, serr, wto, ovr, pud, ies, irq, ext;
    int err_count = 0, cmp_count = 0, wdt_seen = 0, cyc = 0, t1, t2, n;
    int regs[6];
    int wexp[4] = '{4, 2, 1, 4};
    ////////////////////////////////
    // Clock, cycle count and tally of watchdog ticks leaving the block.
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wto === 1'b1) begin
            wdt_seen <= wdt_seen + 1;
        end
    end
    tmz_timer dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(cke), .i_psel(psel), .i_penable(pena),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(serr),
        .i_ext_count(ext), .i_sleep(sleep), .i_clear_watchdog(cwd), .i_wdt_tick(wtk), .o_wdt_tick(wto),
        .o_overflow_req(ovr), .o_port_pullup_disable(pud), .o_ext_irq_edge_select(ies), .o_irq(irq));
    tmz_ext_source src_u (.i_ref_clk(clk), .o_pin(ext));
    ////////////////////////////////
    // Helpers: random source, compare, verdict.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One bus transfer; the request holds until ready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pena <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (k >= 20) begin
            check("ready", 1, 0);
            tally_and_finish();
        end
        q = rdat;
        e = serr;
        psel <= 1'b0;
        pena <= 1'b0;
    endtask
    // Register write and read against the model; the clear register acts on status.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rd, er);
        if (a == 12'h010) begin
            regs[3] = regs[3] & ~d;
        end else if (a != 12'h00c) begin
            regs[a >> 2] = d;
        end
    endtask
    task automatic rdx(input logic [11:0] a, input string what);
        apb(1'b0, a, 32'h0, rd, er);
        check(what, regs[a >> 2], rd);
    endtask
    task automatic wait_irq(input int lim, output int c);
        c = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            c++;
            if (c > lim) begin
                check("irq wait", 1, 0);
                tally_and_finish();
            end
        end
    endtask
    // Restart the count at a fixed phase and time the overflow.
    task automatic wrap_time(input logic [7:0] opt, input logic [7:0] cnt, output int c);
        logic [7:0] ic;
        n = rnd();
        ic = n[7:0] & 8'hdb | 8'h20;
        wr(12'h000, opt);
        wr(12'h004, 8'h00);
        wr(12'h008, ic);
        wr(12'h010, 8'h01);
        wr(12'h014, 8'h01);
        while (cyc % 4 != 0) @(posedge clk);
        wr(12'h004, cnt);
        check("early request", 0, ovr);
        wait_irq(2400, c);
        regs[2] = ic | 8'h04;
        regs[3] = 1;
        rdx(12'h008, "control flag");
        rdx(12'h00c, "status");
        check("overflow request", 1, ovr);
    endtask
    // Watchdog tick or clear pulse, then a random gap.
    task automatic tick(input logic clr);
        @(posedge clk);
        wtk <= ~clr;
        cwd <= clr;
        @(posedge clk);
        wtk <= 1'b0;
        cwd <= 1'b0;
        repeat (3 + (rnd() & 3)) @(posedge clk);
    endtask
    ////////////////////////////////
    // Main sequence.
    initial begin
        regs = '{255, 0, 0, 0, 0, 0};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            rdx(12'(a * 4), "reset value");
        end
        check("pullup pin", 1, pud);
        check("edge pin", 1, ies);
        apb(1'b0, 12'h018, 32'h0, rd, er);
        check("unmapped error", 1, er);
        check("unmapped data", 0, rd);
        wr(12'h00c, 8'hff);
        rdx(12'h00c, "read-only status");
        n = rnd();
        wr(12'h000, n[7:0] & 8'hc0 | 8'h08);
        repeat (3) @(posedge clk);
        check("pullup pin", n[7], pud);
        check("edge pin", n[6], ies);
        $display("register test done");
        wrap_time(8'h08, 8'hff, t1);
        check("inhibit", 1, t1 >= 9 && t1 <= 18);
        for (int r = -1; r < 8; r++) begin
            wrap_time(r < 0 ? 8'h0f : 8'(r), 8'hfe, t2);
            wrap_time(r < 0 ? 8'h0f : 8'(r), 8'hff, t1);
            n = r < 0 ? 4 : 8 << r;
            check("step", 1, t2 - t1 >= n - 3 && t2 - t1 <= n + 3);
        end
        wr(12'h000, 8'h08);
        sleep <= 1'b1;
        wr(12'h010, 8'h01);
        wr(12'h004, 8'hff);
        repeat (40) @(posedge clk);
        check("asleep", 0, irq);
        sleep <= 1'b0;
        wait_irq(30, t1);
        // With the clock enable low nothing may move, not even the inhibit count.
        wr(12'h010, 8'h01);
        wr(12'h004, 8'hff);
        cke <= 1'b0;
        repeat (40) @(posedge clk);
        check("frozen", 0, irq);
        cke <= 1'b1;
        wait_irq(30, t1);
        regs[3] = 1;
        wr(12'h014, 8'h00);
        repeat (2) @(posedge clk);
        check("masked", 0, irq);
        wr(12'h014, 8'h01);
        repeat (2) @(posedge clk);
        check("unmasked", 1, irq);
        wr(12'h010, 8'h01);
        rdx(12'h00c, "cleared status");
        check("cleared", 0, irq);
        $display("timer test done");
        for (int e = 0; e < 2; e++) begin
            wr(12'h000, 8'h28 | 8'(e << 4));
            wr(12'h008, 8'h00);
            wr(12'h010, 8'h01);
            wr(12'h004, 8'hff);
            repeat (10) @(posedge clk);
            check("idle pin", 0, irq);
            src_u.move(1'b1, 10);
            check("rising edge", e == 0, irq);
            src_u.move(1'b0, 10);
            check("falling edge", 1, irq);
            check("request off", 0, ovr);
            regs[1] = 0;
            regs[2] = 4;
            rdx(12'h004, "count");
            rdx(12'h008, "flag without enable");
        end
        $display("counter test done");
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, wopt[i]);
            tick(1'b1);
            n = wdt_seen;
            repeat (4) tick(1'b0);
            check("wdt ticks", wexp[i], wdt_seen - n);
        end
        wr(12'h000, 8'h09);
        tick(1'b1);
        n = wdt_seen;
        tick(1'b0);
        tick(1'b1);
        tick(1'b0);
        check("wdt after clear", 0, wdt_seen - n);
        $display("watchdog test done");
        tally_and_finish();
    end
endmodule // eight_bit_timer_with_shared_prescaler_test
`default_nettype wire
